// [vio_defs.svh]
// Offsets, field positions, reset values and counts of the overlay block
`ifndef VIO_DEFS_SVH
`define VIO_DEFS_SVH
`define VIO_A_GCTRL 8'h00
`define VIO_A_STAT 8'h04
`define VIO_A_BUFWR 8'h08
`define VIO_A_LYR_BIT 7
`define VIO_NBUF 5
`define VIO_NLYR 4
`define VIO_NWORD 16
`define VIO_NLREG 6
`define VIO_G_EN 0
`define VIO_G_INTL 1
`define VIO_C_EN 0
`define VIO_C_BUF 3:1
`define VIO_C_CROP 4
`define VIO_C_CIN 5
`define VIO_C_TRN 6
`define VIO_R_CTRL 3'h0
`define VIO_R_POS 3'h1
`define VIO_R_SIZE 3'h2
`define VIO_R_TIME 3'h3
`define VIO_R_COFS 3'h4
`define VIO_R_CSIZE 3'h5
`define VIO_T_BLINK 7:0
`define VIO_T_TMO 15:8
`define VIO_BW_ENT 15:0
`define VIO_BW_IDX 19:16
`define VIO_BW_BUF 26:24
`define VIO_E_TRN 15
`define VIO_E_RUN 14:8
`define VIO_E_COL 7:0
`define VIO_FRAMES_UNIT 3'h5
`define VIO_RST_GCTRL 2'h0
`define VIO_RESP_OK 2'h0
`define VIO_RESP_ERR 2'h2
`define VIO_FIFO_W 10
`define VIO_FIFO_D 8
`endif

// [vio_pkg.sv]
// Types of the overlay block
`include "vio_defs.svh"
package vio_pkg;
   typedef logic [31:0] vio_word_t;
   typedef logic [7:0] vio_addr_t;
   typedef logic [7:0] vio_pix_t;
   typedef struct packed {
      logic aw_got;
      vio_addr_t awaddr;
      logic w_got;
      vio_word_t wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      vio_word_t rdata;
      logic [1:0] rresp;
      logic [1:0] gctrl;
      logic [`VIO_NLYR-1:0][`VIO_NLREG-1:0][31:0] lreg;
      logic [`VIO_NBUF-1:0][`VIO_NWORD-1:0][15:0] bmem;
      logic [10:0] col;
      logic [10:0] row;
      logic [2:0] fdiv;
      logic [`VIO_NLYR-1:0][3:0] ptr;
      logic [`VIO_NLYR-1:0][6:0] run;
      logic [`VIO_NLYR-1:0][7:0] bcnt;
      logic [`VIO_NLYR-1:0][7:0] tcnt;
      logic [`VIO_NLYR-1:0] vis;
      logic [`VIO_NLYR-1:0] tmo;
   } vio_state_t;
endpackage : vio_pkg

// [vio_fifo.sv]
// Output pixel FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module vio_fifo #(
   parameter int W = 10,
   parameter int D = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } vio_fifo_t;
   vio_fifo_t f_reg, f_next;
   logic push, pop;
   // Full is a true count, so a stalled drain stops the source
   assign in_ready = ce && (f_reg.cnt != (AW+1)'(D));
   assign out_valid = (f_reg.cnt != '0);
   assign out_data = f_reg.mem[f_reg.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready && ce;
   always_comb begin
      f_next = f_reg;
      if (push) begin
         f_next.mem[f_reg.wp] = in_data;
         f_next.wp = (f_reg.wp == (AW)'(D - 1)) ? '0 : f_reg.wp + 1'b1;
      end
      if (pop) begin
         f_next.rp = (f_reg.rp == (AW)'(D - 1)) ? '0 : f_reg.rp + 1'b1;
      end
      if (push && !pop) begin
         f_next.cnt = f_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         f_next.cnt = f_reg.cnt - 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         f_reg <= '0;
      end else if (ce) begin
         f_reg <= f_next;
      end
   end
endmodule : vio_fifo
`default_nettype wire

// [vio_overlay.sv]
// Run-length bitmap overlay compositor with AXI4-Lite registers
// Contract
// - Five bitmap buffers, four composited layers
// - Each layer keeps its own properties
// - Overlay only in interlaced output mode
// - Buffers hold and decode run-length data
// - Programmable horizontal and vertical layer position
// - Any start row accepted, even past bottom
// - Blink toggles every setting times five frames
// - Timeout switches layer off after elapsed frames
// - Crop offsets measured from bitmap top-left
// - Crop outside keeps, inside removes rectangle
// - Shown only when assigned and globally enabled
// - Global enable acts from the same edge that raises the write response
// - Layer enable write touches that layer only
`timescale 1ns/10ps
`default_nettype none
`include "vio_defs.svh"
module vio_overlay (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // AXI4-Lite write
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire vio_pkg::vio_addr_t s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire vio_pkg::vio_word_t s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire vio_pkg::vio_addr_t s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output vio_pkg::vio_word_t s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Pixel stream in
   input wire logic in_valid,
   output logic in_ready,
   input wire vio_pkg::vio_pix_t in_data,
   input wire logic in_sof,
   input wire logic in_sol,
   // Pixel stream out
   output logic out_valid,
   input wire logic out_ready,
   output vio_pkg::vio_pix_t out_data,
   output logic out_sof,
   output logic out_sol
);
   import vio_pkg::*;
   vio_state_t s_reg, s_next;
   logic in_fire, act, tick, wr_go, wr_lyr, f_ready;
   logic [10:0] ccol, crow;
   logic [`VIO_FIFO_W-1:0] f_din, f_dout;
   vio_pix_t pix;
   logic lin [`VIO_NLYR];
   logic draw [`VIO_NLYR];
   logic inrect [`VIO_NLYR];
   logic [15:0] ent [`VIO_NLYR];
   logic [3:0] pe [`VIO_NLYR];
   logic [6:0] re [`VIO_NLYR];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   function automatic vio_word_t merge(input vio_word_t o, input vio_word_t d,
                                       input logic [3:0] st);
      vio_word_t r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   // Unsigned window test; one extra bit keeps base plus length from wrapping
   function automatic logic in_span(input logic [10:0] v, input logic [15:0] base,
                                    input logic [15:0] len);
      return ({1'b0, v} >= {1'b0, base[10:0]}) &&
             ({1'b0, v} < ({1'b0, base[10:0]} + {1'b0, len[10:0]}));
   endfunction : in_span

   function automatic vio_word_t rd_reg(input vio_state_t s, input vio_addr_t a,
                                        output logic err);
      vio_word_t r;
      r = '0;
      err = 1'b0;
      if (a == `VIO_A_GCTRL) begin
         r = {30'h0, s.gctrl};
      end else if (a == `VIO_A_STAT) begin
         r = {24'h0, s.tmo, s.vis};
      end else if (a == `VIO_A_BUFWR) begin
         r = '0;
      end else if (a[`VIO_A_LYR_BIT] && a[4:2] < 3'(`VIO_NLREG) && a[1:0] == 2'h0) begin
         r = s.lreg[a[6:5]][a[4:2]];
      end else begin
         err = 1'b1;
      end
      return r;
   endfunction : rd_reg

   // Readies drop with ce, so no handshake is lost while the state is frozen
   assign s_axi_awready = ce && !s_reg.aw_got && !s_reg.bvalid;
   assign s_axi_wready = ce && !s_reg.w_got && !s_reg.bvalid;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_arready = ce && !s_reg.rvalid;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rdata = s_reg.rdata;
   assign s_axi_rresp = s_reg.rresp;

   assign act = s_reg.gctrl[`VIO_G_EN] && s_reg.gctrl[`VIO_G_INTL];
   assign in_ready = f_ready;
   assign in_fire = in_valid && f_ready;
   assign ccol = in_sof || in_sol ? 11'h000 : s_reg.col + 11'h001;
   assign crow = in_sof ? 11'h000 : (in_sol ? s_reg.row + 11'h001 : s_reg.row);
   assign tick = in_fire && in_sof && (s_reg.fdiv == `VIO_FRAMES_UNIT - 3'h1);
   assign wr_go = s_reg.aw_got && s_reg.w_got;
   assign wr_lyr = wr_go && s_reg.awaddr[`VIO_A_LYR_BIT];

   for (genvar l = 0; l < `VIO_NLYR; l++) begin : g_lyr
      logic [31:0] ctrl, pos, size, tim, cofs, csz;
      logic [2:0] bsel;
      logic [10:0] bx, by;
      logic shown, bon;
      assign ctrl = s_reg.lreg[l][`VIO_R_CTRL];
      assign pos = s_reg.lreg[l][`VIO_R_POS];
      assign size = s_reg.lreg[l][`VIO_R_SIZE];
      assign tim = s_reg.lreg[l][`VIO_R_TIME];
      assign cofs = s_reg.lreg[l][`VIO_R_COFS];
      assign csz = s_reg.lreg[l][`VIO_R_CSIZE];
      assign bsel = ctrl[`VIO_C_BUF];
      // A new frame restarts the run-length walk at its first entry
      assign pe[l] = in_sof ? 4'h0 : s_reg.ptr[l];
      assign re[l] = in_sof ? 7'h00 : s_reg.run[l];
      assign ent[l] = (bsel < 3'(`VIO_NBUF)) ? s_reg.bmem[bsel][pe[l]] : 16'h0000;
      // rows past the frame end just never match
      assign lin[l] = ctrl[`VIO_C_EN] && !s_reg.tmo[l] && (bsel < 3'(`VIO_NBUF)) &&
                      in_span(ccol, pos[15:0], size[15:0]) &&
                      in_span(crow, pos[31:16], size[31:16]);
      assign bx = ccol - pos[10:0];
      assign by = crow - pos[26:16];
      assign inrect[l] = in_span(bx, cofs[15:0], csz[15:0]) &&
                         in_span(by, cofs[31:16], csz[31:16]);
      assign shown = !ctrl[`VIO_C_CROP] || (inrect[l] != ctrl[`VIO_C_CIN]);
      assign bon = s_reg.vis[l] || (tim[`VIO_T_BLINK] == 8'h00);
      assign draw[l] = act && lin[l] && shown && bon &&
                       !(ctrl[`VIO_C_TRN] && ent[l][`VIO_E_TRN]);

      AST_POS_X: assert property (draw[l] |-> ccol >= pos[10:0] && crow >= pos[26:16])
         else $error("layer drawn left of or above its position");
      AST_BUF_RANGE: assert property (draw[l] |-> bsel < 3'(`VIO_NBUF))
         else $error("layer drawn from a missing buffer");
      AST_TMO_OFF: assert property (s_reg.tmo[l] |-> !draw[l])
         else $error("timed-out layer still drawn");
      AST_CROP_IN: assert property (draw[l] && ctrl[`VIO_C_CROP] && ctrl[`VIO_C_CIN]
                                    |-> !inrect[l])
         else $error("crop-inside pixel drawn");
      AST_ENABLE: assert property (draw[l] |-> ctrl[`VIO_C_EN] && s_reg.gctrl[`VIO_G_EN])
         else $error("layer drawn without enables");
      AST_TMO_ZERO: assert property (ce && !s_reg.tmo[l] && tim[`VIO_T_TMO] == 8'h00
                                     |=> !s_reg.tmo[l])
         else $error("zero timeout expired");
      AST_BLINK_HOLD: assert property (ce && !tick && !wr_lyr |=> $stable(s_reg.vis[l]))
         else $error("blink toggled off a five-frame tick");
      AST_LYR_ONLY: assert property (ce && wr_lyr && s_reg.awaddr[6:5] != 2'(l)
                                     |=> $stable(s_reg.lreg[l]))
         else $error("write to one layer changed another");
   end

   always_comb begin
      pix = in_data;
      for (int l = 0; l < `VIO_NLYR; l++) begin
         if (draw[l]) begin
            pix = ent[l][`VIO_E_COL];
         end
      end
   end
   assign f_din = {in_sof, in_sol, pix};

   always_comb begin
      logic rerr;
      logic [2:0] wb;
      logic [1:0] wl;
      vio_word_t gm;
      rerr = 1'b0;
      gm = merge({30'h0, s_reg.gctrl}, s_reg.wdata, s_reg.wstrb);
      wb = s_reg.wdata[`VIO_BW_BUF];
      wl = s_reg.awaddr[6:5];
      s_next = s_reg;
      if (in_fire) begin
         s_next.col = ccol;
         s_next.row = crow;
         if (in_sof) begin
            s_next.fdiv = tick ? 3'h0 : s_reg.fdiv + 3'h1;
         end
         for (int l = 0; l < `VIO_NLYR; l++) begin
            s_next.ptr[l] = pe[l];
            s_next.run[l] = re[l];
            if (lin[l]) begin
               if (ent[l][`VIO_E_RUN] == re[l]) begin
                  s_next.ptr[l] = pe[l] + 4'h1;
                  s_next.run[l] = 7'h00;
               end else begin
                  s_next.run[l] = re[l] + 7'h01;
               end
            end
            if (tick && s_reg.lreg[l][`VIO_R_TIME][`VIO_T_BLINK] != 8'h00) begin
               if (s_reg.bcnt[l] + 8'h01 == s_reg.lreg[l][`VIO_R_TIME][`VIO_T_BLINK]) begin
                  s_next.vis[l] = !s_reg.vis[l];
                  s_next.bcnt[l] = 8'h00;
               end else begin
                  s_next.bcnt[l] = s_reg.bcnt[l] + 8'h01;
               end
            end
            if (tick && !s_reg.tmo[l] && s_reg.lreg[l][`VIO_R_TIME][`VIO_T_TMO] != 8'h00) begin
               if (s_reg.tcnt[l] + 8'h01 == s_reg.lreg[l][`VIO_R_TIME][`VIO_T_TMO]) begin
                  s_next.tmo[l] = 1'b1;
               end else begin
                  s_next.tcnt[l] = s_reg.tcnt[l] + 8'h01;
               end
            end
         end
      end
      if (s_axi_awvalid && s_axi_awready) begin
         s_next.aw_got = 1'b1;
         s_next.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_next.w_got = 1'b1;
         s_next.wdata = s_axi_wdata;
         s_next.wstrb = s_axi_wstrb;
      end
      if (wr_go) begin
         s_next.aw_got = 1'b0;
         s_next.w_got = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = `VIO_RESP_OK;
         if (s_reg.awaddr == `VIO_A_GCTRL) begin
            s_next.gctrl = gm[1:0];
         end else if (s_reg.awaddr == `VIO_A_STAT) begin
            s_next.bresp = `VIO_RESP_OK;
         end else if (s_reg.awaddr == `VIO_A_BUFWR) begin
            if (wb < 3'(`VIO_NBUF)) begin
               s_next.bmem[wb][s_reg.wdata[`VIO_BW_IDX]] = s_reg.wdata[`VIO_BW_ENT];
            end
         end else if (wr_lyr && s_reg.awaddr[4:2] < 3'(`VIO_NLREG) &&
                      s_reg.awaddr[1:0] == 2'h0) begin
            s_next.lreg[wl][s_reg.awaddr[4:2]] =
               merge(s_reg.lreg[wl][s_reg.awaddr[4:2]], s_reg.wdata, s_reg.wstrb);
            // A control write restarts blink and timeout; a same-cycle expiry still stands
            if (s_reg.awaddr[4:2] == `VIO_R_CTRL) begin
               s_next.bcnt[wl] = 8'h00;
               s_next.tcnt[wl] = 8'h00;
               s_next.tmo[wl] = s_next.tmo[wl] && !s_reg.tmo[wl];
               s_next.vis[wl] = 1'b1;
            end
         end else begin
            s_next.bresp = `VIO_RESP_ERR;
         end
      end
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_next.rvalid = 1'b1;
         s_next.rdata = rd_reg(s_reg, s_axi_araddr, rerr);
         s_next.rresp = rerr ? `VIO_RESP_ERR : `VIO_RESP_OK;
      end
      if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '0;
         s_reg.gctrl <= `VIO_RST_GCTRL;
         s_reg.vis <= '1;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   vio_fifo #(
      .W(`VIO_FIFO_W),
      .D(`VIO_FIFO_D)
   ) u_fifo (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .in_valid(in_valid),
      .in_ready(f_ready),
      .in_data(f_din),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(f_dout)
   );
   assign out_sof = f_dout[9];
   assign out_sol = f_dout[8];
   assign out_data = f_dout[7:0];

   AST_PASS: assert property (in_fire && !act |-> f_din[7:0] == in_data)
      else $error("pixel altered while overlay inactive");
   AST_TOP_LAYER: assert property (in_fire && draw[3] |-> f_din[7:0] == ent[3][7:0])
      else $error("top layer not drawn on top");
   AST_BRESP: assert property (ce && wr_go |=> s_axi_bvalid)
      else $error("write response late");
   AST_GCTRL_AT_B: assert property (ce && wr_go && s_reg.awaddr == `VIO_A_GCTRL &&
                                    s_reg.wstrb[0] |=> s_reg.gctrl == $past(s_reg.wdata[1:0]))
      else $error("global enable not applied by response");
endmodule : vio_overlay
`default_nettype wire

// [vio_sink.sv]
// Pixel sink model that drains the overlay output with stalls
`timescale 1ns/10ps
`default_nettype none
module vio_sink (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Stream from the block
   input wire logic valid,
   output logic ready,
   input wire logic [9:0] word,
   // Stall request from the bench
   input wire logic stall
);
   logic [9:0] q[$];
   // Ready moves only after an edge, so a word is never half taken
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ready <= 1'b0;
      end else begin
         if (valid && ready) begin
            q.push_back(word);
         end
         ready <= !stall;
      end
   end
endmodule : vio_sink
`default_nettype wire

// [tb_vio.sv]
// Self-checking testbench of the overlay compositor
`timescale 1ns/10ps
`default_nettype none
`include "vio_defs.svh"
module tb;
   import vio_pkg::*;
   logic clk, rstn, hold, stall, ce;
   logic awvalid, wvalid, bready, arvalid, rready, in_valid, in_sof, in_sol;
   logic awready, wready, bvalid, arready, rvalid, in_ready, out_valid, out_ready;
   logic out_sof, out_sol;
   vio_addr_t awaddr, araddr;
   vio_word_t wdata, rdata, rd;
   logic [1:0] bresp, rresp, resp;
   vio_pix_t in_data, out_data;
   int num_errors, samples_checked;
   logic [9:0] expq[$];
   logic [8:0] ovl[8];

   vio_overlay uut (.clk(clk), .rstn(rstn), .ce(ce),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .in_valid(in_valid),
      .in_ready(in_ready), .in_data(in_data), .in_sof(in_sof), .in_sol(in_sol),
      .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
      .out_sof(out_sof), .out_sol(out_sol));
   vio_sink sink (.clk(clk), .rstn(rstn), .valid(out_valid), .ready(out_ready),
      .word({out_sof, out_sol, out_data}), .stall(stall));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) stall <= hold || ($urandom_range(0, 3) == 0);

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Each channel is released only at the edge that takes it
   task automatic axw(input vio_addr_t a, input vio_word_t d, input logic [1:0] er);
      logic ga, gw, db;
      db = 1'b0;
      // An edge passes first, so bready is never lowered and raised at once
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!db) begin
         @(negedge clk);
         ga = awvalid && awready;
         gw = wvalid && wready;
         db = bvalid;
         resp = bresp;
         @(posedge clk);
         if (ga) awvalid <= 1'b0;
         if (gw) wvalid <= 1'b0;
         if (db) bready <= 1'b0;
      end
      chk("bresp", resp, er);
   endtask : axw

   task automatic rchk(input string what, input vio_addr_t a, input vio_word_t e,
                       input logic [1:0] er);
      logic ga, db;
      db = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!db) begin
         @(negedge clk);
         ga = arvalid && arready;
         db = rvalid;
         rd = rdata;
         resp = rresp;
         @(posedge clk);
         if (ga) arvalid <= 1'b0;
         if (db) rready <= 1'b0;
      end
      chk(what, rd, e);
      chk("rresp", resp, er);
   endtask : rchk

   function automatic vio_addr_t la(input int l, input int r);
      return vio_addr_t'(8'h80 + l * 32 + r * 4);
   endfunction : la

   task automatic lset(input int l, input vio_word_t pos, input vio_word_t sz,
                       input vio_word_t ctl);
      axw(la(l, `VIO_R_POS), pos, `VIO_RESP_OK);
      axw(la(l, `VIO_R_SIZE), sz, `VIO_RESP_OK);
      axw(la(l, `VIO_R_CTRL), ctl, `VIO_RESP_OK);
   endtask : lset

   task automatic bw(input logic [2:0] b, input logic [3:0] i, input logic [15:0] e);
      axw(`VIO_A_BUFWR, {5'h00, b, 4'h0, i, e}, `VIO_RESP_OK);
   endtask : bw

   // Valid stays up between pixels; the caller lowers it after the burst
   task automatic send(input vio_pix_t p, input logic f, input logic l);
      logic got;
      in_data <= p;
      in_sof <= f;
      in_sol <= l;
      in_valid <= 1'b1;
      got = 1'b0;
      while (!got) begin
         @(negedge clk);
         got = in_ready;
         @(posedge clk);
      end
   endtask : send

   task automatic drain(input string what);
      int n;
      n = 0;
      in_valid <= 1'b0;
      while (sink.q.size() < expq.size() && n < 2000) begin
         @(posedge clk);
         n++;
      end
      chk({what, " count"}, sink.q.size(), expq.size());
      while (expq.size() > 0 && sink.q.size() > 0) begin
         chk(what, sink.q.pop_front(), expq.pop_front());
      end
      sink.q.delete();
      expq.delete();
      $display("test %s done", what);
   endtask : drain

   // Only row 0 carries overlay; later lines must pass untouched
   task automatic frame(input int nl, input string what);
      vio_pix_t p;
      logic f, l;
      for (int y = 0; y < nl; y++) begin
         for (int x = 0; x < 8; x++) begin
            p = vio_pix_t'($urandom);
            f = (y == 0 && x == 0);
            l = (x == 0);
            send(p, f, l);
            expq.push_back({f, l, (y == 0 && ovl[x][8]) ? ovl[x][7:0] : p});
         end
      end
      drain(what);
   endtask : frame

   task automatic ticks(input string what);
      vio_pix_t p;
      for (int i = 0; i < 5; i++) begin
         p = vio_pix_t'($urandom);
         send(p, 1'b1, 1'b1);
         expq.push_back({2'b11, p});
      end
      drain(what);
   endtask : ticks

   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (30000) @(posedge clk);
      num_errors++;
      final_report();
   end

   initial begin
      {rstn, hold, awvalid, wvalid, bready, arvalid, rready, in_valid, in_sof, in_sol} = '0;
      {awaddr, araddr, wdata, in_data} = '0;
      ce = 1'b1;
      ovl = '{default: 9'h000};
      num_errors = 0;
      samples_checked = 0;
      void'($urandom(19));
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rchk("gctrl", `VIO_A_GCTRL, 32'h0, `VIO_RESP_OK);
      rchk("status", `VIO_A_STAT, 32'h0000_000F, `VIO_RESP_OK);
      rchk("bufwr", `VIO_A_BUFWR, 32'h0, `VIO_RESP_OK);
      rchk("hole", 8'h40, 32'h0, `VIO_RESP_ERR);
      axw(8'h44, 32'h1, `VIO_RESP_ERR);
      // Sink stalls until the buffer refuses, then drains
      hold <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         vio_pix_t pq;
         pq = vio_pix_t'($urandom);
         send(pq, 1'b0, 1'b0);
         expq.push_back({2'b00, pq});
      end
      in_valid <= 1'b0;
      @(negedge clk);
      chk("in_ready full", in_ready, 1'b0);
      @(posedge clk);
      hold <= 1'b0;
      drain("fifo off");
      bw(3'h0, 4'h0, 16'h7FA5);
      bw(3'h1, 4'h0, 16'h7F3C);
      bw(3'h2, 4'h0, 16'h0111);
      bw(3'h2, 4'h1, 16'h7F22);
      bw(3'h4, 4'h0, 16'h7F5A);
      lset(0, 32'h2, 32'h0001_0003, 32'h05);
      lset(1, 32'h4, 32'h0001_0002, 32'h03);
      lset(3, 32'h6, 32'h0001_0001, 32'h09);
      axw(`VIO_A_GCTRL, 32'h1, `VIO_RESP_OK);
      frame(2, "progressive");
      axw(`VIO_A_GCTRL, 32'h3, `VIO_RESP_OK);
      ovl = '{9'h000, 9'h000, 9'h111, 9'h111, 9'h13C, 9'h13C, 9'h15A, 9'h000};
      frame(2, "layers");
      axw(la(1, `VIO_R_CTRL), 32'h0, `VIO_RESP_OK);
      axw(la(3, `VIO_R_CTRL), 32'h0, `VIO_RESP_OK);
      rchk("ctrl0", la(0, `VIO_R_CTRL), 32'h05, `VIO_RESP_OK);
      axw(la(0, `VIO_R_COFS), 32'h1, `VIO_RESP_OK);
      axw(la(0, `VIO_R_CSIZE), 32'h0001_0002, `VIO_RESP_OK);
      lset(0, 32'h1, 32'h0001_0004, 32'h11);
      ovl = '{9'h000, 9'h000, 9'h1A5, 9'h1A5, 9'h000, 9'h000, 9'h000, 9'h000};
      frame(1, "crop outside");
      axw(la(0, `VIO_R_CTRL), 32'h31, `VIO_RESP_OK);
      ovl = '{9'h000, 9'h1A5, 9'h000, 9'h000, 9'h1A5, 9'h000, 9'h000, 9'h000};
      frame(1, "crop inside");
      lset(0, 32'h07FF_0001, 32'h0001_0004, 32'h01);
      rchk("pos", la(0, `VIO_R_POS), 32'h07FF_0001, `VIO_RESP_OK);
      ovl = '{default: 9'h000};
      frame(2, "low start");
      // Five frames give exactly one tick whatever the divider phase
      for (int l = 0; l < 4; l++) begin
         axw(la(l, `VIO_R_TIME), (l == 0) ? 32'h0200 : 32'(l % 3), `VIO_RESP_OK);
         lset(l, 32'h7, 32'h0001_0001, 32'h01);
      end
      ticks("tick one");
      rchk("status 1", `VIO_A_STAT, 32'h0000_000D, `VIO_RESP_OK);
      ticks("tick two");
      rchk("status 2", `VIO_A_STAT, 32'h0000_001B, `VIO_RESP_OK);
      final_report();
   end
endmodule : tb
`default_nettype wire
